/* File: logic/cem_mode_ctl.sv */
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Function
// - current mode is one bit in pc capability metadata, 0 cap, 1 address
// - with hybrid on, only the mode bit of the pc capability decides the execution mode
// - address mode data accesses and prefetches are authorized by default data cap
// - jumps and instruction prefetch stay authorized by the pc capability
// - address mode cap-width loads/stores use default data cap, register as address
// - address mode capability csr access uses low bits, writes set address checked
// - address mode decoder returns modified instructions to integer behaviour
// - address mode maps compressed capability load/store to float encodings
// - capability instructions and csrs still decode in address mode
// - without hybrid option the block always runs in capability mode
// - mode field only kept for execute capabilities, else update is no-op
// - capability without execute permission reports mode bit 0
// - capability mode indirect jump copies target mode bit into pc
// - two switch instructions flip pc mode to address or capability
// - one instruction writes a capability mode bit, another reads it
// - capability transfers carry the mode bit
// - pc reads tagged in capability mode, untagged in address mode
// - hybrid block leaves reset in address mode
// - one user capability csr holds the default data capability
// - default data csr needs no system register permission
// - mode write clears tag if sealed, sets mode from operand bit 0
module cem_mode_ctl (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire cem_pkg::cem_cap_s     pcc_cap,
  input  wire logic                  op_valid,
  input  wire cem_pkg::cem_op_e      op_kind,
  input  wire cem_pkg::cem_cap_s     op_rs1,
  input  wire logic                  op_integ_ok,
  input  wire logic                  op_rs2_lsb,
  output logic                       res_valid,
  output cem_pkg::cem_cap_s          res_cap,
  output logic [31:0]                res_int,
  output logic                       flush,
  output logic                       exec_mode,
  output logic                       pcc_tag,
  input  wire logic                  mem_valid,
  input  wire cem_pkg::cem_mem_e     mem_kind,
  input  wire logic [31:0]           mem_addr,
  input  wire cem_pkg::cem_cap_s     mem_rs1,
  output logic                       mem_done,
  output logic                       mem_ok,
  output logic                       mem_from_ddc,
  input  wire logic                  csr_valid,
  input  wire logic                  csr_wen,
  input  wire cem_pkg::cem_cap_s     csr_wcap,
  input  wire logic                  csr_integ_ok,
  output logic                       csr_rvalid,
  output cem_pkg::cem_cap_s          csr_rcap,
  input  wire logic                  dec_valid,
  input  wire logic [15:0]           dec_instr,
  output logic                       dec_cap_ld,
  output logic                       dec_cap_st,
  output logic                       dec_fp_ld,
  output logic                       dec_fp_st,
  output logic                       dec_std,
  output logic                       dec_cap_isa
);
  import cem_pkg::*;

  logic [31:0] ctrl_r;
  logic        pc_mode_r;
  cem_cap_s    ddc_r;
  cem_cap_s    ddc_nxt;
  logic        hyb;
  logic        amode;
  logic        acc;
  logic        wr;
  logic        mapped;
  logic [31:0] rd_nxt;
  logic        m_ld;
  logic        m_st;
  logic        m_fl;
  logic        m_fs;
  logic        is_data;
  logic        data_ddc;
  logic        mode_chg;
  logic        mode_new;
  logic        hyb_nxt;
  logic        exec_mode_nxt;

  cem_auth_if auth ();

  // mode bit as seen through execute permission
  function automatic logic mode_of(input cem_cap_s c);
    mode_of = c.perm[PERM_X] ? c.mbit : 1'b0;
  endfunction

  // address update that drops the tag when not representable
  function automatic cem_cap_s set_address_checked(input cem_cap_s c, input logic [31:0] a);
    cem_cap_s r;
    r = c;
    r.addr = a;
    if (c.sealed || a < c.base || a > c.top) begin
      r.tag = 1'b0;
    end
    set_address_checked = r;
  endfunction

  function automatic logic apb_hit(input logic [11:0] a);
    apb_hit = (a == OFF_CTRL) || (a == OFF_STATUS) || (a == OFF_DDC_ADDR) ||
              (a == OFF_DDC_BASE) || (a == OFF_DDC_TOP) || (a == OFF_DDC_META);
  endfunction

  // effective mode: hybrid switched off pins capability mode
  always_comb begin
    hyb = ctrl_r[CTRL_HYB];
    amode = hyb && pc_mode_r;
  end

  // apb access phase decode
  always_comb begin
    acc = psel && penable && pready;
    wr = acc && pwrite;
    mapped = apb_hit(paddr);
  end

  // read mux, sampled in the setup cycle so data is ready at access
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (paddr == OFF_CTRL) begin
      rd_nxt = ctrl_r;
    end else if (paddr == OFF_STATUS) begin
      rd_nxt[ST_MODE] = amode;
      rd_nxt[ST_TAG] = !amode;
      rd_nxt[ST_HYB] = hyb;
    end else if (paddr == OFF_DDC_ADDR) begin
      rd_nxt = ddc_r.addr;
    end else if (paddr == OFF_DDC_BASE) begin
      rd_nxt = ddc_r.base;
    end else if (paddr == OFF_DDC_TOP) begin
      rd_nxt = ddc_r.top;
    end else if (paddr == OFF_DDC_META) begin
      rd_nxt[META_TAG] = ddc_r.tag;
      rd_nxt[META_SEAL] = ddc_r.sealed;
      rd_nxt[META_PERM +: PERM_W] = ddc_r.perm;
      rd_nxt[META_M] = mode_of(ddc_r);
    end
  end

  // zero wait apb slave: ready in every access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rd_nxt : 32'h0000_0000;
      pslverr <= psel && !penable && !apb_hit(paddr);
    end
  end

  // control register, software steers the hybrid option
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RST;
    end else if (wr && paddr == OFF_CTRL) begin
      ctrl_r <= {31'h0000_0000, pwdata[CTRL_HYB]};
    end
  end

  // next pc mode from switch instructions and indirect jumps
  always_comb begin
    mode_chg = 1'b0;
    mode_new = pc_mode_r;
    if (op_valid && hyb) begin
      case (op_kind)
        OP_SWI: begin
          mode_chg = !amode;
          mode_new = 1'b1;
        end
        OP_SWY: begin
          mode_chg = amode;
          mode_new = 1'b0;
        end
        OP_JALR: begin
          mode_chg = !amode && (mode_of(op_rs1) != pc_mode_r);
          mode_new = amode ? pc_mode_r : mode_of(op_rs1);
        end
        default: begin
          mode_chg = 1'b0;
        end
      endcase
    end
  end

  // mode after this edge, a control write included, so the pins never lag the authority choice
  always_comb begin
    hyb_nxt = (wr && paddr == OFF_CTRL) ? pwdata[CTRL_HYB] : hyb;
    exec_mode_nxt = hyb_nxt && (mode_chg ? mode_new : pc_mode_r);
  end

  // pc mode bit, reset into address mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_mode_r <= 1'b1;
    end else if (mode_chg) begin
      pc_mode_r <= mode_new;
    end
  end

  // flush pulse on a switch or jump mode change so nothing decoded in the old mode retires; a control write changes the mode with no flush
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flush <= 1'b0;
      exec_mode <= 1'b1;
      pcc_tag <= 1'b0;
    end else begin
      flush <= mode_chg;
      exec_mode <= exec_mode_nxt;
      pcc_tag <= !exec_mode_nxt;
    end
  end

  // mode write and mode read results
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid <= 1'b0;
      res_cap <= '0;
      res_int <= 32'h0000_0000;
    end else begin
      res_valid <= op_valid && (op_kind == OP_MODEW || op_kind == OP_MODER);
      res_cap <= op_rs1;
      res_int <= 32'h0000_0000;
      if (op_valid && op_kind == OP_MODEW) begin
        res_cap.tag <= op_rs1.tag && !op_rs1.sealed && op_integ_ok;
        if (op_rs1.perm[PERM_X] && op_integ_ok) begin
          res_cap.mbit <= op_rs2_lsb;
        end
      end
      if (op_valid && op_kind == OP_MODER) begin
        res_int[0] <= op_integ_ok && mode_of(op_rs1);
      end
    end
  end

  // choice of authority for a memory access
  always_comb begin
    is_data = (mem_kind != MEM_FETCH) && (mem_kind != MEM_PREF_I) && (mem_kind != MEM_JUMP);
    data_ddc = amode && is_data;
    auth.cap = data_ddc ? ddc_r : (is_data ? mem_rs1 : pcc_cap);
    auth.addr = mem_addr;
    auth.need = '0;
    case (mem_kind)
      MEM_LOAD, MEM_PREF_R: auth.need[PERM_R] = 1'b1;
      MEM_STORE, MEM_PREF_W: auth.need[PERM_W_BIT] = 1'b1;
      MEM_CAP_LOAD: begin
        auth.need[PERM_R] = 1'b1;
        auth.need[PERM_C] = 1'b1;
      end
      MEM_CAP_STORE: begin
        auth.need[PERM_W_BIT] = 1'b1;
        auth.need[PERM_C] = 1'b1;
      end
      default: auth.need[PERM_X] = 1'b1;
    endcase
  end

  cem_auth_chk u_chk (
    .a (auth.chk)
  );

  // registered authorization answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_done <= 1'b0;
      mem_ok <= 1'b0;
      mem_from_ddc <= 1'b0;
    end else begin
      mem_done <= mem_valid;
      mem_ok <= mem_valid && auth.ok;
      mem_from_ddc <= mem_valid && data_ddc;
    end
  end

  // default data capability update from csr port, then apb
  always_comb begin
    ddc_nxt = ddc_r;
    if (csr_valid && csr_wen) begin
      if (amode) begin
        ddc_nxt = set_address_checked(ddc_r, csr_wcap.addr);
      end else begin
        ddc_nxt = csr_wcap;
        ddc_nxt.tag = csr_wcap.tag && csr_integ_ok;
      end
    end else if (wr && paddr == OFF_DDC_ADDR) begin
      ddc_nxt = set_address_checked(ddc_r, pwdata);
    end else if (wr && paddr == OFF_DDC_BASE) begin
      ddc_nxt.base = pwdata;
    end else if (wr && paddr == OFF_DDC_TOP) begin
      ddc_nxt.top = pwdata;
    end else if (wr && paddr == OFF_DDC_META) begin
      ddc_nxt.tag = pwdata[META_TAG];
      ddc_nxt.sealed = pwdata[META_SEAL];
      ddc_nxt.perm = pwdata[META_PERM +: PERM_W];
      ddc_nxt.mbit = pwdata[META_M] && pwdata[META_PERM + PERM_X];
    end
  end

  // user csr, no system register permission check on this path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ddc_r <= '{tag: 1'b1, sealed: 1'b0, perm: DDC_PERM_RST, mbit: 1'b0,
                 base: DDC_BASE_RST, top: DDC_TOP_RST, addr: DDC_BASE_RST};
    end else begin
      ddc_r <= ddc_nxt;
    end
  end

  // csr read: address only in address mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_rvalid <= 1'b0;
      csr_rcap <= '0;
    end else begin
      csr_rvalid <= csr_valid;
      csr_rcap <= ddc_r;
      if (amode) begin
        csr_rcap <= '{tag: 1'b0, sealed: 1'b0, perm: '0, mbit: 1'b0,
                      base: '0, top: '0, addr: ddc_r.addr};
      end
    end
  end

  cem_cmap u_cmap (
    .instr     (dec_instr),
    .addr_mode (amode),
    .cap_ld    (m_ld),
    .cap_st    (m_st),
    .fp_ld     (m_fl),
    .fp_st     (m_fs)
  );

  // decode qualifiers follow the mode the pc holds now
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_cap_ld <= 1'b0;
      dec_cap_st <= 1'b0;
      dec_fp_ld <= 1'b0;
      dec_fp_st <= 1'b0;
      dec_std <= 1'b0;
      dec_cap_isa <= 1'b0;
    end else begin
      dec_cap_ld <= dec_valid && m_ld;
      dec_cap_st <= dec_valid && m_st;
      dec_fp_ld <= dec_valid && m_fl;
      dec_fp_st <= dec_valid && m_fs;
      dec_std <= dec_valid && amode;
      dec_cap_isa <= dec_valid;
    end
  end
endmodule

/* File: pkg/cem_pkg.sv */
package cem_pkg;
  // capability field widths
  localparam int XLEN = 32;
  localparam int PERM_W = 4;

  // permission bit positions
  localparam int PERM_R = 0;
  localparam int PERM_W_BIT = 1;
  localparam int PERM_X = 2;
  localparam int PERM_C = 3;

  // apb register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_DDC_ADDR = 12'h008;
  localparam logic [11:0] OFF_DDC_BASE = 12'h00c;
  localparam logic [11:0] OFF_DDC_TOP = 12'h010;
  localparam logic [11:0] OFF_DDC_META = 12'h014;

  // control and status fields
  localparam int CTRL_HYB = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int ST_MODE = 0;
  localparam int ST_TAG = 1;
  localparam int ST_HYB = 2;

  // metadata word layout
  localparam int META_TAG = 0;
  localparam int META_SEAL = 1;
  localparam int META_PERM = 2;
  localparam int META_M = 6;

  // default data capability reset value
  localparam logic [31:0] DDC_BASE_RST = 32'h0000_0000;
  localparam logic [31:0] DDC_TOP_RST = 32'hffff_ffff;
  localparam logic [3:0] DDC_PERM_RST = 4'hb;

  // compressed load/store fields
  localparam logic [1:0] CQ0 = 2'h0;
  localparam logic [1:0] CQ2 = 2'h2;
  localparam logic [1:0] C32 = 2'h3;
  localparam logic [2:0] CF3_LD = 3'h3;
  localparam logic [2:0] CF3_ST = 3'h7;

  typedef enum logic {MODE_CAP, MODE_ADDR} cem_mode_e;
  typedef enum logic [2:0] {OP_NONE, OP_JALR, OP_SWI, OP_SWY, OP_MODEW, OP_MODER} cem_op_e;
  typedef enum logic [3:0] {MEM_LOAD, MEM_STORE, MEM_PREF_R, MEM_PREF_W, MEM_CAP_LOAD,
                            MEM_CAP_STORE, MEM_FETCH, MEM_PREF_I, MEM_JUMP} cem_mem_e;

  typedef struct packed {
    logic             tag;
    logic             sealed;
    logic [PERM_W-1:0] perm;
    logic             mbit;
    logic [XLEN-1:0]  base;
    logic [XLEN-1:0]  top;
    logic [XLEN-1:0]  addr;
  } cem_cap_s;
endpackage

/* File: pkg/cem_auth_if.sv */
`timescale 1ns/1ps
interface cem_auth_if;
  import cem_pkg::*;
  cem_cap_s          cap;
  logic [XLEN-1:0]   addr;
  logic [PERM_W-1:0] need;
  logic              ok;
  modport req (output cap, output addr, output need, input ok);
  modport chk (input cap, input addr, input need, output ok);
endinterface

/* File: logic/cem_auth_chk.sv */
`timescale 1ns/1ps
module cem_auth_chk (
  cem_auth_if.chk a
);
  import cem_pkg::*;

  // tagged, unsealed, permits, and address inside [base, top)
  always_comb begin
    a.ok = a.cap.tag && !a.cap.sealed && ((a.cap.perm & a.need) == a.need) &&
           (a.addr >= a.cap.base) && (a.addr < a.cap.top);
  end
endmodule

/* File: logic/cem_cmap.sv */
`timescale 1ns/1ps
module cem_cmap (
  input  wire logic [15:0] instr,
  input  wire logic        addr_mode,
  output logic             cap_ld,
  output logic             cap_st,
  output logic             fp_ld,
  output logic             fp_st
);
  import cem_pkg::*;
  logic cq;
  logic ld;
  logic st;

  // only quadrants 0 and 2 carry the stack/reg load-store slots
  always_comb begin
    cq = (instr[1:0] == CQ0) || (instr[1:0] == CQ2);
    ld = cq && (instr[15:13] == CF3_LD);
    st = cq && (instr[15:13] == CF3_ST);
    cap_ld = ld && !addr_mode;
    cap_st = st && !addr_mode;
    fp_ld = ld && addr_mode;
    fp_st = st && addr_mode;
  end
endmodule

/* File: verification/cem_mode_ctl_monitor.sv */
`timescale 1ns/1ps
module cem_mode_ctl_monitor
  import cem_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        op_valid,
  input wire cem_op_e     op_kind,
  input wire cem_cap_s    op_rs1,
  input wire logic        op_integ_ok,
  input wire logic        op_rs2_lsb,
  input wire logic        res_valid,
  input wire cem_cap_s    res_cap,
  input wire logic [31:0] res_int,
  input wire logic        flush,
  input wire logic        exec_mode,
  input wire logic        pcc_tag,
  input wire logic        mem_valid,
  input wire cem_mem_e    mem_kind,
  input wire logic        mem_done,
  input wire logic        mem_from_ddc,
  input wire logic        dec_valid,
  input wire logic [15:0] dec_instr,
  input wire logic        dec_cap_ld,
  input wire logic        dec_fp_ld
);
  logic hyb_r;

  // shadow of the hybrid enable, follows completed apb writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hyb_r <= 1'b1;
    end else if (psel && penable && pready && pwrite && paddr == OFF_CTRL) begin
      hyb_r <= pwdata[CTRL_HYB];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  pc_tag_a: assert property (pcc_tag == !exec_mode)
    else $error("pc tag not inverse of mode");
  to_addr_a: assert property (op_valid && op_kind == OP_SWI && !exec_mode && hyb_r
    |=> exec_mode && flush)
    else $error("switch to address mode missed");
  to_cap_a: assert property (op_valid && op_kind == OP_SWY && exec_mode && hyb_r
    |=> !exec_mode && flush)
    else $error("switch to capability mode missed");
  switch_noop_a: assert property (op_valid
    && ((op_kind == OP_SWI && exec_mode) || (op_kind == OP_SWY && !exec_mode))
    |=> !flush && exec_mode == $past(exec_mode))
    else $error("redundant switch changed mode");
  jump_mode_a: assert property (op_valid && op_kind == OP_JALR && !exec_mode && hyb_r
    && op_rs1.perm[PERM_X] |=> exec_mode == $past(op_rs1.mbit))
    else $error("jump did not copy mode bit");
  fixed_cap_a: assert property (!hyb_r && !$past(hyb_r) |-> !exec_mode)
    else $error("mode not capability with hybrid off");
  data_auth_a: assert property (mem_valid |=> mem_done
    && mem_from_ddc == ($past(exec_mode) && !($past(mem_kind) inside {MEM_FETCH, MEM_PREF_I, MEM_JUMP})))
    else $error("wrong authority for access");
  mode_read_a: assert property (op_valid && op_kind == OP_MODER
    |=> res_valid && res_int == {31'h0, $past(op_rs1.mbit && op_rs1.perm[PERM_X] && op_integ_ok)})
    else $error("mode read value wrong");
  mode_write_a: assert property (op_valid && op_kind == OP_MODEW
    && op_rs1.perm[PERM_X] && op_integ_ok
    |=> res_valid && res_cap.mbit == $past(op_rs2_lsb)
    && res_cap.tag == $past(op_rs1.tag && !op_rs1.sealed))
    else $error("mode write result wrong");
  cload_map_a: assert property (dec_valid && dec_instr[1:0] == CQ2 && dec_instr[15:13] == CF3_LD
    |=> dec_fp_ld == $past(exec_mode) && dec_cap_ld == !$past(exec_mode))
    else $error("compressed load mapped wrong");
endmodule

bind cem_mode_ctl cem_mode_ctl_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .op_valid, .op_kind, .op_rs1, .op_integ_ok, .op_rs2_lsb, .res_valid, .res_cap, .res_int, .flush, .exec_mode,
  .pcc_tag, .mem_valid, .mem_kind, .mem_done, .mem_from_ddc, .dec_valid, .dec_instr, .dec_cap_ld, .dec_fp_ld);

/* File: verification/cem_mode_ctl_test.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module cem_mode_ctl_test;
  import cem_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, mem_addr = '0, res_int;
  logic        pready, pslverr, er, op_valid = 0, op_integ_ok = 1, op_rs2_lsb = 0;
  logic        res_valid, flush, exec_mode, pcc_tag, mem_valid = 0, mem_done, mem_ok, mem_from_ddc;
  logic        csr_valid = 0, csr_wen = 0, csr_integ_ok = 1, csr_rvalid, dec_valid = 0;
  logic [15:0] dec_instr = '0;
  logic        dec_cap_ld, dec_cap_st, dec_fp_ld, dec_fp_st, dec_std, dec_cap_isa;
  cem_cap_s    pcc_cap, op_rs1 = '0, mem_rs1 = '0, csr_wcap = '0, res_cap, csr_rcap, cx;
  cem_op_e     op_kind = OP_NONE;
  cem_mem_e    mem_kind = MEM_LOAD;
  int          error_cnt = 0, samples_checked = 0;

  cem_mode_ctl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pcc_cap, .op_valid, .op_kind, .op_rs1, .op_integ_ok, .op_rs2_lsb, .res_valid, .res_cap, .res_int, .flush,
    .exec_mode, .pcc_tag, .mem_valid, .mem_kind, .mem_addr, .mem_rs1, .mem_done, .mem_ok, .mem_from_ddc,
    .csr_valid, .csr_wen, .csr_wcap, .csr_integ_ok, .csr_rvalid, .csr_rcap, .dec_valid, .dec_instr,
    .dec_cap_ld, .dec_cap_st, .dec_fp_ld, .dec_fp_st, .dec_std, .dec_cap_isa);

  // 10 mhz clock
  always #50 pclk = ~pclk;

  function automatic cem_cap_s cap(logic [3:0] p, logic m, logic s);
    cap = '{1'b1, s, p, m, 32'h0, 32'hffff_ffff, 32'h40};
  endfunction

  // apb transfer: request held until pready is seen at a rising edge, answer taken at that edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  // ddc csr access, old value and strobe seen one cycle later
  task automatic cq(logic w, logic [31:0] a);
    cem_cap_s c;
    c = cap(4'h3, 1'b0, 1'b0);
    c.addr = a;
    @(posedge pclk);
    csr_valid <= 1'b1;
    csr_wen <= w;
    csr_wcap <= c;
    @(posedge pclk);
    csr_valid <= 1'b0;
    csr_wen <= 1'b0;
    #1;
    `CHK("csr_rvalid", 1'b1, csr_rvalid)
  endtask

  task automatic op(cem_op_e k, cem_cap_s c, logic b);
    @(posedge pclk);
    op_valid <= 1'b1;
    op_kind <= k;
    op_rs1 <= c;
    op_rs2_lsb <= b;
    @(posedge pclk);
    op_valid <= 1'b0;
    #1;
  endtask

  // mode and flush after one instruction
  task automatic opm(cem_op_e k, logic m, logic f);
    op(k, cx, 1'b0);
    `CHK("mode", m, exec_mode)
    `CHK("flush", f, flush)
    `CHK("pc_tag", !m, pcc_tag)
  endtask

  task automatic mq(cem_mem_e k, logic [31:0] a, logic d, logic ok);
    @(posedge pclk);
    mem_valid <= 1'b1;
    mem_kind <= k;
    mem_addr <= a;
    @(posedge pclk);
    mem_valid <= 1'b0;
    #1;
    `CHK("mem_done", 1'b1, mem_done)
    `CHK("from_ddc", d, mem_from_ddc)
    `CHK("mem_ok", ok, mem_ok)
  endtask

  task automatic dq(logic [15:0] i);
    @(posedge pclk);
    dec_valid <= 1'b1;
    dec_instr <= i;
    @(posedge pclk);
    dec_valid <= 1'b0;
    #1;
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the fewer than a hundred cycles used
  initial begin
    repeat (5000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end

  // main sequence
  initial begin
    pcc_cap = cap(4'hf, 1'b0, 1'b0);
    cx = cap(4'hf, 1'b1, 1'b0);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    `CHK("reset_mode", 1'b1, exec_mode)
    `CHK("reset_tag", 1'b0, pcc_tag)
    apb(1'b0, OFF_STATUS, '0);
    `CHK("status", 32'h0000_0005, rd)
    apb(1'b0, OFF_DDC_META, '0);
    `CHK("ddc_meta", 32'h0000_002d, rd)
    apb(1'b0, 12'h018, '0);
    `CHK("unmapped", 1'b1, er)
    apb(1'b1, OFF_DDC_TOP, 32'h100);
    apb(1'b0, OFF_DDC_TOP, '0);
    `CHK("ddc_top", 32'h100, rd)
    mq(MEM_LOAD, 32'h200, 1'b1, 1'b0);
    // data kinds go through ddc, fetch kinds through pc
    for (int i = 0; i < 9; i++) begin
      mq(cem_mem_e'(i), 32'h40, i < 6, 1'b1);
    end
    // address mode csr: write moves the address only, read shows the address only
    cq(1'b1, 32'h80);
    `CHK("csr_rd_perm", 4'h0, csr_rcap.perm)
    cq(1'b0, '0);
    `CHK("csr_rd_addr", 32'h80, csr_rcap.addr)
    `CHK("csr_rd_tag", 1'b0, csr_rcap.tag)
    apb(1'b0, OFF_DDC_META, '0);
    `CHK("ddc_meta_kept", 32'h0000_002d, rd)
    dq(16'h6002);
    `CHK("fp_ld", 1'b1, dec_fp_ld)
    `CHK("std", 1'b1, dec_std)
    `CHK("cap_isa", 1'b1, dec_cap_isa)
    dq(16'he002);
    `CHK("fp_st", 1'b1, dec_fp_st)
    opm(OP_SWI, 1'b1, 1'b0);
    opm(OP_SWY, 1'b0, 1'b1);
    opm(OP_SWY, 1'b0, 1'b0);
    opm(OP_SWI, 1'b1, 1'b1);
    opm(OP_SWY, 1'b0, 1'b1);
    opm(OP_JALR, 1'b1, 1'b1);
    apb(1'b1, OFF_CTRL, 32'h0);
    `CHK("hyb_off", 1'b0, exec_mode)
    opm(OP_SWI, 1'b0, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h1);
    `CHK("hyb_on", 1'b1, exec_mode)
    opm(OP_SWY, 1'b0, 1'b1);
    mq(MEM_LOAD, 32'h40, 1'b0, 1'b0);
    dq(16'h6002);
    `CHK("cap_ld", 1'b1, dec_cap_ld)
    `CHK("cap_std", 1'b0, dec_std)
    `CHK("cap_isa_c", 1'b1, dec_cap_isa)
    dq(16'he002);
    `CHK("cap_st", 1'b1, dec_cap_st)
    op(OP_MODEW, cap(4'hf, 1'b0, 1'b0), 1'b1);
    `CHK("mw_valid", 1'b1, res_valid)
    `CHK("mw_mode", 1'b1, res_cap.mbit)
    op(OP_MODEW, cap(4'hf, 1'b0, 1'b1), 1'b0);
    `CHK("mw_tag", 1'b0, res_cap.tag)
    op(OP_MODER, cx, 1'b0);
    `CHK("mr_x", 32'h1, res_int)
    op(OP_MODER, cap(4'hb, 1'b1, 1'b0), 1'b0);
    `CHK("mr_nox", 32'h0, res_int)
    cq(1'b0, '0);
    `CHK("csr_perm", 4'hb, csr_rcap.perm)
    `CHK("csr_addr", 32'h80, csr_rcap.addr)
    end_of_test();
  end
endmodule
